// ---- rtl/frgafc_top.sv ----
// all-frame mode control: counts messages needing every frame, forwards
// frame words to the host and marks each frame end in all-frame mode with a status packet.
// assumes the frame decoder presents words and frame ends on clk_i.
`timescale 1ns/10ps
`include "frgafc_map.svh"
module frgafc_top (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [`FRGAFC_AW-1:0] addr_i,
  input wire logic [`FRGAFC_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [`FRGAFC_DW-1:0] rdata_o,
  input wire frgafc_pkg::frgafc_word_type word_i,
  input wire logic frame_end_i,
  input wire logic tmp_addr_pending_i,
  output frgafc_pkg::frgafc_pkt_type pkt_o,
  output logic all_frame_o,
  output logic irq_o
);
  import frgafc_pkg::*;

  logic [`FRGAFC_CNT_W-1:0] count, next_count;
  logic force_all_frame_bit, next_force_all_frame_bit;
  frgafc_mode_type mode, next_mode;
  logic [`FRGAFC_IRQ_W-1:0] irq_stat, next_irq_stat;
  logic [`FRGAFC_IRQ_W-1:0] irq_mask, next_irq_mask;
  frgafc_pkt_type next_pkt;
  logic [`FRGAFC_DW-1:0] next_rdata;

  logic inc, dec, stay, wr_ctrl;
  logic [`FRGAFC_IRQ_W-1:0] ev;

  assign wr_ctrl = wr_i && (addr_i == `FRGAFC_OFF_CTRL);
  // vector word of a type that may be fragmented
  assign inc = word_i.valid && (word_i.kind == FRGAFC_WORD_VECT) &&
    (word_i.vtype == FRGAFC_VT_SECURE || word_i.vtype == FRGAFC_VT_ALPHA ||
     word_i.vtype == FRGAFC_VT_HEXBIN);
  assign dec = wr_ctrl &&
    wdata_i[`FRGAFC_CTRL_DECREMENT_ALL_FRAME_FLAG];

  always_comb begin
    next_count = count;
    if (inc && !dec) begin
      // saturate high rather than wrap back to zero
      if (count != `FRGAFC_CNT_MAX) begin
        next_count = count + 1'b1;
      end
    end else if (dec && !inc) begin
      if (count != '0) begin
        next_count = count - 1'b1;
      end
    end
    next_force_all_frame_bit = wr_ctrl ?
      wdata_i[`FRGAFC_CTRL_FORCE_ALL_FRAME_BIT] : force_all_frame_bit;
  end

  // stay in all-frame while any reason remains
  assign stay = (next_count != '0) || tmp_addr_pending_i ||
    next_force_all_frame_bit;

  always_comb begin
    next_mode = mode;
    unique case (mode)
      FRGAFC_NORMAL: begin
        if (stay) begin
          next_mode = FRGAFC_ALLFRAME;
        end
      end
      FRGAFC_ALLFRAME: begin
        if (!stay) begin
          next_mode = FRGAFC_NORMAL;
        end
      end
    endcase
  end

  // packet out: a frame end in all-frame mode takes priority; decoder never offers a word
  // in the same cycle as a frame end
  always_comb begin
    next_pkt = '0;
    if (frame_end_i && mode == FRGAFC_ALLFRAME) begin
      next_pkt.valid = 1'b1;
      next_pkt.is_status = 1'b1;
      next_pkt.eof = 1'b1;
    end else if (word_i.valid) begin
      next_pkt.valid = 1'b1;
      next_pkt.kind = word_i.kind;
      next_pkt.data = word_i.data;
    end
  end

  always_comb begin
    ev = '0;
    ev[`FRGAFC_IRQ_ENTER] = (mode == FRGAFC_NORMAL) &&
      (next_mode == FRGAFC_ALLFRAME);
    ev[`FRGAFC_IRQ_LEAVE] = (mode == FRGAFC_ALLFRAME) &&
      (next_mode == FRGAFC_NORMAL);
    ev[`FRGAFC_IRQ_EOF] = next_pkt.eof;
    next_irq_stat = irq_stat;
    if (wr_i && addr_i == `FRGAFC_OFF_IRQ_STAT) begin
      next_irq_stat = irq_stat & ~wdata_i[`FRGAFC_IRQ_W-1:0];
    end
    // set wins over a clear in the same cycle
    next_irq_stat = next_irq_stat | ev;
    next_irq_mask = irq_mask;
    if (wr_i && addr_i == `FRGAFC_OFF_IRQ_MASK) begin
      next_irq_mask = wdata_i[`FRGAFC_IRQ_W-1:0];
    end
  end

  always_comb begin
    next_rdata = '0;
    if (rd_i) begin
      unique case (addr_i)
        `FRGAFC_OFF_CTRL: begin
          next_rdata[`FRGAFC_CTRL_FORCE_ALL_FRAME_BIT] = force_all_frame_bit;
        end
        `FRGAFC_OFF_STATUS: begin
          next_rdata[`FRGAFC_ST_ALL] = (mode == FRGAFC_ALLFRAME);
          next_rdata[`FRGAFC_ST_TMP] = tmp_addr_pending_i;
          next_rdata[`FRGAFC_ST_FORCE_ALL_FRAME_BIT] = force_all_frame_bit;
        end
        `FRGAFC_OFF_IRQ_STAT: next_rdata[`FRGAFC_IRQ_W-1:0] = irq_stat;
        `FRGAFC_OFF_IRQ_MASK: next_rdata[`FRGAFC_IRQ_W-1:0] = irq_mask;
        `FRGAFC_OFF_COUNT: next_rdata = count;
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count <= '0;
      force_all_frame_bit <= 1'b0;
      mode <= FRGAFC_NORMAL;
      irq_stat <= '0;
      irq_mask <= `FRGAFC_MASK_RST;
      pkt_o <= '0;
      rdata_o <= '0;
    end else begin
      count <= next_count;
      force_all_frame_bit <= next_force_all_frame_bit;
      mode <= next_mode;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      pkt_o <= next_pkt;
      rdata_o <= next_rdata;
    end
  end

  assign all_frame_o = (mode == FRGAFC_ALLFRAME);
  assign irq_o = |(irq_stat & irq_mask);

  // a vector of a fragmentable type, seen while the counter has room
  sequence s_vec_in;
    inc && !dec && count != `FRGAFC_CNT_MAX;
  endsequence

  // a decrement that no vector in the same cycle cancels
  sequence s_dec_in;
    dec && !inc && count != '0;
  endsequence

  // last decrement with no other cause left to stay in all-frame
  sequence s_last_dec;
    dec && !inc && count == 8'h01 && !tmp_addr_pending_i &&
    !wdata_i[`FRGAFC_CTRL_FORCE_ALL_FRAME_BIT];
  endsequence

  // frame end seen while every frame is being decoded
  sequence s_frame_end;
    frame_end_i && all_frame_o;
  endsequence

  // a word offered by the frame decoder, not masked by a frame end
  sequence s_word_in;
    word_i.valid && !frame_end_i;
  endsequence

  a_count_up: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    s_vec_in |=> count == $past(count) + 1'b1 && all_frame_o)
    else $error("counter did not rise on vector");

  a_vec_enter: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    !all_frame_o ##0 s_vec_in |=> $rose(all_frame_o))
    else $error("vector did not enter all-frame");

  a_count_down: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    s_dec_in |=> count == $past(count) - 1'b1)
    else $error("counter did not drop on decrement");

  // mode and cause registers move on the same edge
  a_leave_cond: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    $fell(all_frame_o) |-> count == '0 && !force_all_frame_bit &&
    !$past(tmp_addr_pending_i))
    else $error("left all-frame with cause pending");

  a_last_leave: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    s_last_dec |=> !all_frame_o && count == '0)
    else $error("stayed in all-frame after last decrement");

  a_stay_busy: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    count != '0 |-> all_frame_o)
    else $error("normal mode with nonzero counter");

  a_force_stay: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    force_all_frame_bit |-> all_frame_o)
    else $error("normal mode with force bit set");

  // the pending input is sampled, so mode follows one edge later
  a_tmp_stay: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    tmp_addr_pending_i |=> all_frame_o)
    else $error("normal mode with temp address pending");

  a_word_fwd: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    s_word_in |=> pkt_o.valid && !pkt_o.is_status &&
    pkt_o.data == $past(word_i.data))
    else $error("word not forwarded");

  a_word_kind: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    s_word_in |=> !pkt_o.eof && pkt_o.kind == $past(word_i.kind))
    else $error("word forwarded with wrong kind");

  a_eof_flag: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    s_frame_end |=> pkt_o.valid && pkt_o.is_status && pkt_o.eof)
    else $error("frame end status missing eof");

  a_eof_refused: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    frame_end_i && !all_frame_o |=> !pkt_o.valid)
    else $error("status packet sent in normal mode");

  a_status_only: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    pkt_o.is_status |-> pkt_o.valid && pkt_o.eof)
    else $error("status packet without eof");

  a_zero_hold: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    dec && !inc && count == '0 |=> count == '0)
    else $error("counter moved below zero");

  a_irq_level: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    $rose(all_frame_o) && irq_mask[`FRGAFC_IRQ_ENTER] |-> irq_o)
    else $error("enter event not signalled");

  a_leave_irq: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    $fell(all_frame_o) |-> irq_stat[`FRGAFC_IRQ_LEAVE])
    else $error("leave event not latched");

  a_eof_irq: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    pkt_o.eof |-> irq_stat[`FRGAFC_IRQ_EOF])
    else $error("eof event not latched");

  // a clear only sticks for bits with no event in the same cycle
  a_irq_clear: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    wr_i && addr_i == `FRGAFC_OFF_IRQ_STAT |=>
    (irq_stat & $past(wdata_i[`FRGAFC_IRQ_W-1:0]) & ~$past(ev)) == '0)
    else $error("status bit not cleared");

  a_mask_write: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    wr_i && addr_i == `FRGAFC_OFF_IRQ_MASK |=>
    irq_mask == $past(wdata_i[`FRGAFC_IRQ_W-1:0]))
    else $error("mask write lost");

  a_rdata_idle: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    !rd_i |=> rdata_o == '0)
    else $error("read data outside read cycle");

  a_rdata_count: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    rd_i && addr_i == `FRGAFC_OFF_COUNT |=> rdata_o == $past(count))
    else $error("counter read back wrong");
endmodule

// ---- rtl/frgafc_map.svh ----
// constants for the all-frame control block: register offsets, field
// positions, reset values and counter width.
// included by the package, the top module and the bench.
`ifndef FRGAFC_MAP_SVH
`define FRGAFC_MAP_SVH

`define FRGAFC_AW 4
`define FRGAFC_DW 8
`define FRGAFC_CNT_W 8
`define FRGAFC_CNT_MAX 8'hff

`define FRGAFC_OFF_CTRL 4'h0
`define FRGAFC_OFF_STATUS 4'h1
`define FRGAFC_OFF_IRQ_STAT 4'h2
`define FRGAFC_OFF_IRQ_MASK 4'h3
`define FRGAFC_OFF_COUNT 4'h4

// control register fields
`define FRGAFC_CTRL_DECREMENT_ALL_FRAME_FLAG 0
`define FRGAFC_CTRL_FORCE_ALL_FRAME_BIT 1
// status register fields
`define FRGAFC_ST_ALL 0
`define FRGAFC_ST_TMP 1
`define FRGAFC_ST_FORCE_ALL_FRAME_BIT 2
// interrupt fields
`define FRGAFC_IRQ_ENTER 0
`define FRGAFC_IRQ_LEAVE 1
`define FRGAFC_IRQ_EOF 2
`define FRGAFC_IRQ_W 3

`define FRGAFC_MASK_RST 3'h0
`define FRGAFC_CTRL_RST 8'h00

`endif

// ---- rtl/frgafc_pkg.sv ----
// types for the all-frame control block.
// constants live in frgafc_map.svh.
`include "frgafc_map.svh"
package frgafc_pkg;
  typedef enum logic [1:0] {
    FRGAFC_WORD_ADDR,
    FRGAFC_WORD_VECT,
    FRGAFC_WORD_MSG
  } frgafc_word_kind_type;

  // word found in a frame, from the frame decoder
  typedef struct packed {
    logic valid;
    frgafc_word_kind_type kind;
    logic [2:0] vtype;
    logic [31:0] data;
  } frgafc_word_type;

  // packet toward the host
  typedef struct packed {
    logic valid;
    logic is_status;
    logic eof;
    frgafc_word_kind_type kind;
    logic [31:0] data;
  } frgafc_pkt_type;

  typedef enum logic [2:0] {
    FRGAFC_VT_SECURE = 3'h0,
    FRGAFC_VT_ALPHA = 3'h5,
    FRGAFC_VT_HEXBIN = 3'h6
  } frgafc_vtype_type;

  typedef enum {
    FRGAFC_NORMAL,
    FRGAFC_ALLFRAME
  } frgafc_mode_type;
endpackage

// ---- sim/frgafc_host.sv ----
// host model: turns message packets into counter decrements.
// assumes the continued flag is bit 0 of a message packet's data.
`timescale 1ns/10ps
module frgafc_host (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire frgafc_pkg::frgafc_pkt_type pkt_i,
  output logic wr_o
);
  import frgafc_pkg::*;
  logic frag;
  logic msg;
  logic [2:0] pend;
  logic [2:0] owe;
  assign msg = pkt_i.valid && !pkt_i.is_status &&
               pkt_i.kind == FRGAFC_WORD_MSG;
  // first continued fragment owes nothing; the last one owes two
  assign owe = !msg ? 3'h0 : pkt_i.data[0] ? {2'h0, frag} :
               {1'b0, frag, !frag};
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      frag <= 1'b0;
      pend <= 3'h0;
    end else begin
      if (msg) begin
        frag <= pkt_i.data[0];
      end
      pend <= pend - {2'h0, pend != 3'h0} + owe;
    end
  end
  // one decrement write per cycle, back to back
  assign wr_o = pend != 3'h0;
endmodule

// ---- sim/frgafc_top_tb_top.sv ----
// bench: drives frame words and registers, mirrors the counter.
// assumes frgafc_host shares the register port for its decrements.
`timescale 1ns/10ps
`include "frgafc_map.svh"
module frgafc_top_tb_top;
  import frgafc_pkg::*;
  logic clk_i = 1'b0, rst_b_i = 1'b0, twr = 1'b0, rd_i = 1'b0;
  logic tmp_addr_pending_i = 1'b0, frame_end_i = 1'b0, hwr, wr_i, irq_o;
  logic all_frame_o;
  logic [3:0] taddr = 4'h0, addr_i;
  logic [7:0] twdata = 8'h00, wdata_i, rdata_o;
  frgafc_word_type word_i = '0;
  frgafc_pkt_type pkt_o;
  int errors = 0, compares = 0, cnt = 0;
  bit mode = 1'b0, frag = 1'b0, frc = 1'b0;
  logic [31:0] seed = 32'hec0a44ba;
  assign wr_i = hwr | twr;
  assign addr_i = hwr ? `FRGAFC_OFF_CTRL : taddr;
  assign wdata_i = hwr ? 8'h01 : twdata;
  frgafc_top u_frgafc_top (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .word_i(word_i), .frame_end_i(frame_end_i),
    .tmp_addr_pending_i(tmp_addr_pending_i), .pkt_o(pkt_o),
    .all_frame_o(all_frame_o), .irq_o(irq_o));
  frgafc_host u_frgafc_host (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .pkt_i(pkt_o), .wr_o(hwr));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input string n, input logic [39:0] got, exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic results;
    if (errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_i) begin
      rd_i <= 1'b1;
      taddr <= a;
    end
    @(posedge clk_i) rd_i <= 1'b0;
    #1 chk("rdata", {32'h0, rdata_o}, {32'h0, e});
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i) begin
      twr <= 1'b1;
      taddr <= a;
      twdata <= d;
    end
    @(posedge clk_i) twr <= 1'b0;
  endtask
  task automatic sync;
    repeat (6) @(posedge clk_i);
    if (cnt == 0 && !frc && tmp_addr_pending_i !== 1'b1) mode = 1'b0;
    #1 chk("mode", {39'h0, all_frame_o}, {39'h0, mode});
    rreg(`FRGAFC_OFF_COUNT, cnt[7:0]);
  endtask
  task automatic frame;
    @(posedge clk_i) frame_end_i <= 1'b1;
    @(posedge clk_i) frame_end_i <= 1'b0;
    #1 chk("eof", {pkt_o.valid, pkt_o.valid & pkt_o.is_status,
      pkt_o.valid & pkt_o.eof}, {3{mode}});
  endtask
  task automatic word(input frgafc_word_kind_type k, input logic [2:0] vt,
                      input bit c);
    int dec;
    seed = lfsr(seed);
    @(posedge clk_i) word_i <= '{1'b1, k, vt, {seed[31:1], c}};
    @(posedge clk_i) word_i <= '0;
    #1 chk("pkt", {pkt_o.valid, pkt_o.kind, pkt_o.data},
      {1'b1, k, seed[31:1], c});
    if (k == FRGAFC_WORD_VECT &&
        (vt == 3'h0 || vt == 3'h5 || vt == 3'h6)) begin
      cnt++;
      mode = 1'b1;
    end
    if (k == FRGAFC_WORD_MSG) begin
      dec = c ? frag : (frag ? 2 : 1);
      cnt = cnt > dec ? cnt - dec : 0;
      frag = c;
    end
    sync;
  endtask
  initial begin
    #4ms;
    errors++;
    results;
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    sync;
    rreg(`FRGAFC_OFF_IRQ_MASK, {5'h0, `FRGAFC_MASK_RST});
    wreg(`FRGAFC_OFF_IRQ_MASK, 8'h07);
    for (int i = 0; i < 3; i++) begin
      word(FRGAFC_WORD_ADDR, 3'h0, 1'b0);
      word(FRGAFC_WORD_VECT, 3'h5, 1'b0);
      word(FRGAFC_WORD_MSG, 3'h0, i < 2);
      if (mode) frame;
    end
    chk("irq", {39'h0, irq_o}, 40'h1);
    rreg(`FRGAFC_OFF_IRQ_STAT, 8'h07);
    wreg(`FRGAFC_OFF_IRQ_STAT, 8'h07);
    @(posedge clk_i);
    #1 chk("irq", {39'h0, irq_o}, 40'h0);
    for (int v = 0; v < 8; v++) word(FRGAFC_WORD_VECT, 3'(v), 1'b0);
    frc = 1'b1;
    wreg(`FRGAFC_OFF_CTRL, 8'h02);
    @(posedge clk_i) tmp_addr_pending_i <= 1'b1;
    rreg(`FRGAFC_OFF_STATUS, 8'h07);
    repeat (4) begin
      wreg(`FRGAFC_OFF_CTRL, 8'h03);
      cnt = cnt > 0 ? cnt - 1 : 0;
    end
    sync;
    frc = 1'b0;
    wreg(`FRGAFC_OFF_CTRL, 8'h00);
    sync;
    @(posedge clk_i) tmp_addr_pending_i <= 1'b0;
    sync;
    frame;
    results;
  end
endmodule
